/* File: logic/arb_strap_bridge.sv */
// Bridge end: arbiter mode strap capture and shared-pin front end.
// Behaviour
// - Strap high at reset end enables arbiter.
// - Strap low at reset end disables arbiter.
// - Host holds strap at the use_internal level through reset.
// - Low CPU request means pending CPU request.
// - Disabled mode ignores CPU request after reset.
// - Enabled: request-zero is initiator zero request.
// - Disabled: request-zero is external arbiter grant.
// - Enabled: request-one is initiator one request.
// - Disabled mode ignores request-one after reset.
// - Enabled: assert CPU grant low to grant.
// - Disabled: grant-zero pin is bridge request.
// - Disabled: grant-one pin is resume output.
// - Grant pins float from reset until driven.
`timescale 1ns/10ps
module arb_strap_bridge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpu_grant,
    input wire logic init0_grant,
    input wire logic init1_grant,
    input wire logic bus_request,
    input wire logic resume,
    output logic arbiter_enabled,
    output logic mode_valid,
    output logic cpu_request,
    output logic init0_request,
    output logic init1_request,
    output logic bus_granted,
    arb_strap_if.bridge pins
);
    import arb_strap_pkg::*;

    // Timing after release: the first edge moves to capture, the second
    // takes the mode, the third drives the pins in their selected roles.
    // The strap level must therefore stand on the pin while reset is held;
    // what the partner does with the pin after release does not matter.
    // A release that is too short to fill the synchroniser is not served.

    // Pin synchronisers; stage one is read only by stage two.
    // They carry no reset: the strap level that stands while reset is
    // held is already in stage two when reset is released.
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    // Front-end state: reset, strap capture, then run.
    front_state_t state_r;
    // Next state, from the walk below.
    front_state_t state_nxt;
    // Captured arbiter mode; high means the internal arbiter is on.
    logic mode_r;
    // Registered level of the CPU grant pin.
    logic cpu_gnt_r;
    // Registered level of the grant-zero pin.
    logic initiator_zero_grant_n_r;
    // Registered level of the grant-one pin.
    logic initiator_one_grant_n_r;
    // Shared enable of all three grant pins; low drives them.
    logic oe_n_r;
    // Mode-valid flag, kept apart from the enable so it is a plain flop.
    logic valid_r;
    // Registered CPU request for the arbiter core.
    logic cpu_req_r;
    // Registered initiator zero request.
    logic initiator_zero_request_n_r;
    // Registered initiator one request.
    logic initiator_one_request_n_r;
    // Registered grant from the external arbiter.
    logic granted_r;

    // Passes a request level only in run and only in the mode that owns
    // the pin. A level on a pin that has no meaning in the captured mode
    // never reaches the arbiter core, whatever the partner leaves on it.
    function automatic logic mode_gate(
        input logic in_run,
        input logic mode,
        input logic owner,
        input logic level
    );
        mode_gate = in_run & (mode == owner) & level;
    endfunction

    // Decoded synchronised pins, high meaning asserted.
    // The CPU request pin doubles as the strap.
    wire logic cpu_pin_low = !sync2_r[2];
    // Request zero, or the external grant in disabled mode.
    wire logic initiator_zero_request_n_pin_low = !sync2_r[1];
    // Request one, meaningless in disabled mode.
    wire logic initiator_one_request_n_pin_low = !sync2_r[0];
    // The strap is taken from stage two in the first cycle after release,
    // where it still holds the level sampled while reset was held.
    wire logic capture = (state_r == ST_STRAP);
    // Outside the capture cycle the mode is kept until the next reset.
    wire logic mode_nxt = capture ? sync2_r[2] : mode_r;
    // Pins are driven and requests decoded only in run.
    wire logic run = (state_r == ST_RUN);
    // Pin function selected by the captured mode.
    wire logic initiator_zero_grant_n_sel = mode_r ? !init0_grant : !bus_request;
    wire logic initiator_one_grant_n_sel = mode_r ? !init1_grant : !resume;
    // Request views for the arbiter core, each gated by its mode.
    wire logic cpu_req_nxt =
        mode_gate(run, mode_r, MODE_INTERNAL, cpu_pin_low);
    wire logic initiator_zero_request_n_nxt =
        mode_gate(run, mode_r, MODE_INTERNAL, initiator_zero_request_n_pin_low);
    wire logic initiator_one_request_n_nxt =
        mode_gate(run, mode_r, MODE_INTERNAL, initiator_one_request_n_pin_low);
    wire logic granted_nxt =
        mode_gate(run, mode_r, MODE_EXTERNAL, initiator_zero_request_n_pin_low);

    // Walk from reset through strap capture into run; run is held.
    // An unused code falls back to reset, so a glitch cannot skip capture.
    always_comb begin
        case (state_r)
            // First edge after release; stage two already holds the strap.
            ST_RESET: state_nxt = ST_STRAP;
            // Capture cycle: the mode is taken at the coming edge.
            ST_STRAP: state_nxt = ST_RUN;
            // Run is left only by a new reset.
            ST_RUN: state_nxt = ST_RUN;
            // The fourth code is unused.
            default: state_nxt = ST_RESET;
        endcase
    end

    // Pin drives and enables come straight from their registers.
    assign pins.host_cpu_bus_grant_n = cpu_gnt_r;
    assign pins.host_cpu_bus_grant_oe_n = oe_n_r;
    assign pins.initiator_zero_grant_n = initiator_zero_grant_n_r;
    assign pins.initiator_zero_grant_oe_n = oe_n_r;
    assign pins.initiator_one_grant_n = initiator_one_grant_n_r;
    assign pins.initiator_one_grant_oe_n = oe_n_r;
    // User-side views, each straight from its own flop.
    assign arbiter_enabled = mode_r;
    assign mode_valid = valid_r;
    assign cpu_request = cpu_req_r;
    assign init0_request = initiator_zero_request_n_r;
    assign init1_request = initiator_one_request_n_r;
    assign bus_granted = granted_r;

    // Two-flop synchronisers, free running through reset as well.
    // A reset here would hide the strap behind the reset value in the
    // capture cycle, so stage two must follow the pin while reset holds.
    // The request views are gated by run, so nothing reads these flops
    // before they hold a real pin level.
    always_ff @(posedge clk) begin
        sync1_r <= {pins.host_cpu_bus_request_n,
                    pins.initiator_zero_request_n,
                    pins.initiator_one_request_n};
        sync2_r <= sync1_r;
    end

    // The mode is caught by a clocked step after release, never by reset.
    // Reset parks the mode at disabled so no grant is driven by mistake.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Start the walk again on every reset.
            state_r <= ST_RESET;
            mode_r <= MODE_EXTERNAL;
        end else begin
            // The mode moves only in the capture cycle.
            state_r <= state_nxt;
            mode_r <= mode_nxt;
        end
    end

    // Pins float during reset and strap capture, then drive by mode.
    // Floating until the mode is known keeps the bridge off a pin that
    // the partner may still be driving in the other role.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Float at once on reset, with the drives parked inactive.
            oe_n_r <= OE_FLOAT;
            valid_r <= 1'b0;
            cpu_gnt_r <= PIN_IDLE;
            initiator_zero_grant_n_r <= PIN_IDLE;
            initiator_one_grant_n_r <= PIN_IDLE;
        end else begin
            // Enables and the valid flag move together.
            oe_n_r <= !run;
            valid_r <= run;
            // CPU grant means nothing with the arbiter off, so hold it high.
            cpu_gnt_r <= !(run & mode_r & cpu_grant);
            // Grant zero or the bridge request, by mode.
            initiator_zero_grant_n_r <= run ? initiator_zero_grant_n_sel : PIN_IDLE;
            // Grant one or the resume output, by mode.
            initiator_one_grant_n_r <= run ? initiator_one_grant_n_sel : PIN_IDLE;
        end
    end

    // Requests are decoded only in run; disabled mode drops CPU and one.
    // Three cycles pass from a pin change to these views: two in the
    // synchroniser and one here. The arbiter core must allow for that.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // No request or grant is seen while reset holds.
            cpu_req_r <= 1'b0;
            initiator_zero_request_n_r <= 1'b0;
            initiator_one_request_n_r <= 1'b0;
            granted_r <= 1'b0;
        end else begin
            // The decode lives in the gated wires above.
            cpu_req_r <= cpu_req_nxt;
            initiator_zero_request_n_r <= initiator_zero_request_n_nxt;
            initiator_one_request_n_r <= initiator_one_request_n_nxt;
            granted_r <= granted_nxt;
        end
    end
endmodule

/* File: logic/arb_strap_pkg.sv */
// Package with the shared constants and types of the arbiter mode front end.
package arb_strap_pkg;
    // Number of synchroniser stages for every pin input.
    localparam int SYNC_STAGES = 2;
    // Value of the mode flag when the internal arbiter is enabled.
    localparam logic MODE_INTERNAL = 1'b1;
    // Value of the mode flag when the internal arbiter is disabled.
    localparam logic MODE_EXTERNAL = 1'b0;
    // Reset value of every active-low pin output except the strap pin, which follows use_internal in reset (inactive, high).
    localparam logic PIN_IDLE = 1'b1;
    // Reset value of every output enable (low means driving, so high floats).
    localparam logic OE_FLOAT = 1'b1;
    // Front-end states, Gray coded along reset, strap capture and run.
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_STRAP = 2'b01,
        ST_RUN = 2'b11
    } front_state_t;
endpackage

/* File: logic/arb_strap_if.sv */
// Interface carrying the shared arbiter pins between the bridge and its partner.
`timescale 1ns/10ps
interface arb_strap_if;
    // Strap and CPU request pin, driven by the host bridge side.
    logic host_cpu_bus_request_n;
    // CPU grant pin and its enable (low means driven).
    logic host_cpu_bus_grant_n;
    logic host_cpu_bus_grant_oe_n;
    // Request-zero pin, doubling as external arbiter grant.
    logic initiator_zero_request_n;
    // Request-one pin.
    logic initiator_one_request_n;
    // Grant-zero pin, doubling as the bridge bus request, with enable.
    logic initiator_zero_grant_n;
    logic initiator_zero_grant_oe_n;
    // Grant-one pin, doubling as the resume output, with enable.
    logic initiator_one_grant_n;
    logic initiator_one_grant_oe_n;
    // The bridge end owns the grants and reads the requests.
    modport bridge (
        input host_cpu_bus_request_n,
        input initiator_zero_request_n,
        input initiator_one_request_n,
        output host_cpu_bus_grant_n,
        output host_cpu_bus_grant_oe_n,
        output initiator_zero_grant_n,
        output initiator_zero_grant_oe_n,
        output initiator_one_grant_n,
        output initiator_one_grant_oe_n
    );
    // The partner end drives requests and reads the grants.
    modport partner (
        output host_cpu_bus_request_n,
        output initiator_zero_request_n,
        output initiator_one_request_n,
        input host_cpu_bus_grant_n,
        input host_cpu_bus_grant_oe_n,
        input initiator_zero_grant_n,
        input initiator_zero_grant_oe_n,
        input initiator_one_grant_n,
        input initiator_one_grant_oe_n
    );
endinterface

/* File: logic/arb_strap_partner.sv */
// Partner end: host bridge, two initiators or an external arbiter.
`timescale 1ns/10ps
module arb_strap_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic use_internal,
    input wire logic cpu_want,
    input wire logic init0_want,
    input wire logic init1_want,
    input wire logic ext_grant,
    output logic cpu_granted,
    output logic bridge_wants_bus,
    output logic bridge_resume,
    arb_strap_if.partner pins
);
    import arb_strap_pkg::*;

    // Two-stage synchronisers for the pins coming from the bridge.
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    // Registered pin drives.
    logic cpu_req_r;
    logic initiator_zero_request_n_r;
    logic initiator_one_request_n_r;
    // Registered user-side views.
    logic cpu_granted_r;
    logic bridge_wants_r;
    logic resume_r;

    // Pin sample vector: a floated pin reads as inactive high.
    wire logic [2:0] pin_raw = {
        pins.host_cpu_bus_grant_oe_n | pins.host_cpu_bus_grant_n,
        pins.initiator_zero_grant_oe_n | pins.initiator_zero_grant_n,
        pins.initiator_one_grant_oe_n | pins.initiator_one_grant_n
    };
    // In reset the strap level is held; otherwise low requests the bus.
    wire logic cpu_req_nxt = !rst_n ? use_internal : !cpu_want;
    // In external mode request zero carries the grant from an external arbiter.
    wire logic initiator_zero_request_n_nxt = use_internal ? !init0_want : !ext_grant;
    wire logic initiator_one_request_n_nxt = !init1_want;

    // The strap pin is combinational during reset so it follows use_internal throughout.
    assign pins.host_cpu_bus_request_n = rst_n ? cpu_req_r : use_internal;
    assign pins.initiator_zero_request_n = initiator_zero_request_n_r;
    assign pins.initiator_one_request_n = initiator_one_request_n_r;
    assign cpu_granted = cpu_granted_r;
    assign bridge_wants_bus = bridge_wants_r;
    assign bridge_resume = resume_r;

    // Synchronise the incoming grant pins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // Drive requests and register the decoded grants.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_req_r <= PIN_IDLE;
            initiator_zero_request_n_r <= PIN_IDLE;
            initiator_one_request_n_r <= PIN_IDLE;
            cpu_granted_r <= 1'b0;
            bridge_wants_r <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            cpu_req_r <= cpu_req_nxt;
            initiator_zero_request_n_r <= initiator_zero_request_n_nxt;
            initiator_one_request_n_r <= initiator_one_request_n_nxt;
            cpu_granted_r <= use_internal & !sync2_r[2];
            bridge_wants_r <= !use_internal & !sync2_r[1];
            resume_r <= !use_internal & !sync2_r[0];
        end
    end
endmodule

/* File: testbench/arb_strap_chk.sv */
// Checker of the shared arbiter pins seen on the interface.
`timescale 1ns/10ps
module arb_strap_chk
    import arb_strap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_cpu_bus_request_n,
    input wire logic initiator_zero_request_n,
    input wire logic initiator_one_request_n,
    input wire logic host_cpu_bus_grant_n,
    input wire logic host_cpu_bus_grant_oe_n,
    input wire logic initiator_zero_grant_n,
    input wire logic initiator_zero_grant_oe_n,
    input wire logic initiator_one_grant_n,
    input wire logic initiator_one_grant_oe_n
);
    // Strap level seen in reset; the register holds it past release.
    logic mode_r;
    // Sampled only in reset, so a late strap change cannot move it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_r <= host_cpu_bus_request_n;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // First edge after reset is released.
    sequence s_release;
        $rose(rst_n);
    endsequence
    // All three grant pins floating.
    sequence s_float;
        host_cpu_bus_grant_oe_n && initiator_zero_grant_oe_n
            && initiator_one_grant_oe_n;
    endsequence
    property p_float_release;
        s_release |-> s_float;
    endproperty
    property p_idle_release;
        s_release |-> host_cpu_bus_grant_n && initiator_zero_grant_n
            && initiator_one_grant_n;
    endproperty
    property p_drive_bound;
        s_release |-> ##[1:8] !initiator_zero_grant_oe_n
            && !initiator_one_grant_oe_n;
    endproperty
    property p_zero_held;
        !initiator_zero_grant_oe_n |=> !initiator_zero_grant_oe_n;
    endproperty
    property p_one_held;
        !initiator_one_grant_oe_n |=> !initiator_one_grant_oe_n;
    endproperty
    property p_cpu_driven;
        s_release ##0 mode_r |-> ##[1:8] !host_cpu_bus_grant_oe_n;
    endproperty
    property p_cpu_held;
        !host_cpu_bus_grant_oe_n |=> $stable(host_cpu_bus_grant_oe_n);
    endproperty
    property p_float_idle;
        initiator_zero_grant_oe_n |-> initiator_zero_grant_n == PIN_IDLE;
    endproperty
    a_float_release: assert property (p_float_release)
        else $error("Grant pin driven at reset release.");
    a_idle_release: assert property (p_idle_release)
        else $error("Grant pin not idle at reset release.");
    a_drive_bound: assert property (p_drive_bound)
        else $error("Shared grant pins not driven after reset.");
    a_zero_held: assert property (p_zero_held)
        else $error("Grant-zero pin released in mid-run.");
    a_one_held: assert property (p_one_held)
        else $error("Grant-one pin released in mid-run.");
    a_cpu_driven: assert property (p_cpu_driven)
        else $error("CPU grant not driven in internal mode.");
    a_cpu_held: assert property (p_cpu_held)
        else $error("CPU grant enable moved in mid-run.");
    a_float_idle: assert property (p_float_idle)
        else $error("Floating grant-zero pin not idle.");
endmodule

/* File: testbench/pci_arbiter_mode_strap_tb_top.sv */
// Self-checking bench joining the bridge end and the partner end.
`timescale 1ns/10ps
// Waits a bounded time for a match, then compares and counts.
`define CHK(nm, exp, got) begin \
    for (int i = 0; i < 12 && (got) !== (exp); i++) @(negedge clk); \
    n_compared++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("[FAIL] %s expected %b seen %b", nm, exp, got); \
        summarize(); \
    end \
end
module pci_arbiter_mode_strap_tb_top;
    import arb_strap_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, use_internal = 1'b1;
    logic cpu_want = 0, init0_want = 0, init1_want = 0, ext_grant = 0;
    logic cpu_grant = 0, init0_grant = 0, init1_grant = 0;
    logic bus_request = 0, resume = 0;
    logic arbiter_enabled, mode_valid, cpu_request, init0_request;
    logic init1_request, bus_granted, cpu_granted, bridge_wants_bus;
    logic bridge_resume;
    int n_fail = 0, n_compared = 0;
    arb_strap_if bus ();
    // Clock of 5 ns period.
    always #2.5 clk = ~clk;
    arb_strap_bridge u_arb_strap_bridge (.clk(clk), .rst_n(rst_n),
        .cpu_grant(cpu_grant), .init0_grant(init0_grant),
        .init1_grant(init1_grant), .bus_request(bus_request),
        .resume(resume), .arbiter_enabled(arbiter_enabled),
        .mode_valid(mode_valid), .cpu_request(cpu_request),
        .init0_request(init0_request), .init1_request(init1_request),
        .bus_granted(bus_granted), .pins(bus.bridge));
    arb_strap_partner u_arb_strap_partner (.clk(clk), .rst_n(rst_n),
        .use_internal(use_internal), .cpu_want(cpu_want),
        .init0_want(init0_want), .init1_want(init1_want),
        .ext_grant(ext_grant), .cpu_granted(cpu_granted),
        .bridge_wants_bus(bridge_wants_bus),
        .bridge_resume(bridge_resume), .pins(bus.partner));
    arb_strap_chk u_arb_strap_chk (.clk(clk), .rst_n(rst_n),
        .host_cpu_bus_request_n(bus.host_cpu_bus_request_n),
        .initiator_zero_request_n(bus.initiator_zero_request_n),
        .initiator_one_request_n(bus.initiator_one_request_n),
        .host_cpu_bus_grant_n(bus.host_cpu_bus_grant_n),
        .host_cpu_bus_grant_oe_n(bus.host_cpu_bus_grant_oe_n),
        .initiator_zero_grant_n(bus.initiator_zero_grant_n),
        .initiator_zero_grant_oe_n(bus.initiator_zero_grant_oe_n),
        .initiator_one_grant_n(bus.initiator_one_grant_n),
        .initiator_one_grant_oe_n(bus.initiator_one_grant_oe_n));
    // Prints the verdict and ends the run.
    task summarize();
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Resets both ends with the chosen strap and checks the captured mode.
    task start(input logic mode);
        @(negedge clk);
        rst_n = 1'b0;
        {cpu_want, init0_want, init1_want, ext_grant} = 4'h0;
        {cpu_grant, init0_grant, init1_grant, bus_request, resume} = 5'h00;
        use_internal = mode;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        `CHK("mode_valid", 1'b1, mode_valid)
        `CHK("arbiter_enabled", mode, arbiter_enabled)
    endtask
    // Internal arbiter: requests reach the bridge, grants reach the pins.
    task t_internal();
        start(MODE_INTERNAL);
        cpu_want = 1'b1;
        `CHK("cpu_request", 1'b1, cpu_request)
        init0_want = 1'b1;
        `CHK("init0_request", 1'b1, init0_request)
        init1_want = 1'b1;
        `CHK("init1_request", 1'b1, init1_request)
        {cpu_grant, init0_grant, init1_grant} = 3'h7;
        `CHK("cpu_granted", 1'b1, cpu_granted)
        `CHK("cpu_grant_pin", 1'b0, bus.host_cpu_bus_grant_n)
        `CHK("grant0_pin", 1'b0, bus.initiator_zero_grant_n)
        `CHK("grant1_pin", 1'b0, bus.initiator_one_grant_n)
        ext_grant = 1'b1;
        // A refusal has no event to wait on, so a fixed settle is used.
        repeat (8) @(negedge clk);
        `CHK("bus_granted", 1'b0, bus_granted)
        cpu_want = 1'b0;
        `CHK("cpu_request_off", 1'b0, cpu_request)
        `CHK("mode_kept", 1'b1, arbiter_enabled)
    endtask
    // External arbiter: CPU and one requests ignored, pins swap roles.
    task t_external();
        start(MODE_EXTERNAL);
        repeat (4) @(negedge clk);
        {cpu_want, init1_want} = 2'h3;
        repeat (8) @(negedge clk);
        `CHK("cpu_request", 1'b0, cpu_request)
        `CHK("init1_request", 1'b0, init1_request)
        ext_grant = 1'b1;
        `CHK("bus_granted", 1'b1, bus_granted)
        bus_request = 1'b1;
        `CHK("bridge_req_pin", 1'b0, bus.initiator_zero_grant_n)
        `CHK("bridge_wants_bus", 1'b1, bridge_wants_bus)
        resume = 1'b1;
        `CHK("resume_pin", 1'b0, bus.initiator_one_grant_n)
        `CHK("bridge_resume", 1'b1, bridge_resume)
        `CHK("mode_kept", 1'b0, arbiter_enabled)
    endtask
    // Main sequence; the last pass proves a third reset recaptures internal mode.
    initial begin
        t_internal();
        t_external();
        t_internal();
        summarize();
    end
endmodule
